// ===== include/zt_params.svh
// Constants for the zero-turnaround synchronous SRAM port
`ifndef ZT_PARAMS_SVH
`define ZT_PARAMS_SVH

// ****************************************************************
// Organisation
// ****************************************************************
`define ZT_ADDR_W         18
`define ZT_LANES          4
`define ZT_BYTE_W         8
`define ZT_LANE_W         9
`define ZT_PARITY_POS     8

// ****************************************************************
// Burst counter
// ****************************************************************
`define ZT_BURST_W        2
`define ZT_BURST_FIRST    2'h0
`define ZT_BURST_STEP     2'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define ZT_RST_SYNC       3'h0
`define ZT_RST_BIT        1'h0

`endif

// ===== include/zt_pkg.sv
// Types shared by the zero-turnaround SRAM port modules
`default_nettype none

package zt_pkg;

    // Direction that a burst continues in; idle after reset or deselect
    typedef enum logic [1:0] {
        ZT_OP_IDLE,
        ZT_OP_READ,
        ZT_OP_WRITE
    } zt_op_t;

endpackage : zt_pkg

`default_nettype wire

// ===== verilog/zt_burst_seq.sv
// Burst sequence generator for the two lowest address bits
`default_nettype none
`include "zt_params.svh"

module zt_burst_seq
    import zt_pkg::*;
(
    input  wire logic [`ZT_BURST_W-1:0] base_low,
    input  wire logic [`ZT_BURST_W-1:0] count,
    input  wire logic                   interleaved,
    output logic      [`ZT_BURST_W-1:0] addr_low
);

    // Linear wraps inside the four-word block; interleaved flips bits
    always_comb begin
        if (interleaved) begin
            addr_low = base_low ^ count;
        end else begin
            addr_low = base_low + count;
        end
    end

endmodule : zt_burst_seq

`default_nettype wire

// ===== verilog/zt_mem_array.sv
// Storage array with per-lane writes and a registered read port
`default_nettype none
`include "zt_params.svh"

module zt_mem_array
    import zt_pkg::*;
#(
    parameter int ADDR_W = `ZT_ADDR_W,
    parameter int LANES  = `ZT_LANES
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        en,
    input  wire logic                        rd_en,
    input  wire logic [ADDR_W-1:0]           rd_addr,
    output logic      [LANES*`ZT_LANE_W-1:0] rd_data,
    input  wire logic                        wr_en,
    input  wire logic [ADDR_W-1:0]           wr_addr,
    input  wire logic [LANES-1:0]            wr_lanes,
    input  wire logic [LANES*`ZT_LANE_W-1:0] wr_data
);

    logic [LANES*`ZT_LANE_W-1:0] mem [2**ADDR_W];
    logic [LANES*`ZT_LANE_W-1:0] fwd;

    // A read of the word written at the same edge sees the new lanes,
    // so a read right behind a write needs no idle cycle
    always_comb begin
        fwd = mem[rd_addr];
        for (int i = 0; i < LANES; i++) begin
            if (wr_en && wr_lanes[i] && (wr_addr == rd_addr)) begin
                fwd[i*`ZT_LANE_W +: `ZT_LANE_W] = wr_data[i*`ZT_LANE_W +: `ZT_LANE_W];
            end
        end
    end

    // Array has no reset: contents survive reset and sleep
    always_ff @(posedge clk) begin
        if (en && wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (wr_lanes[i]) begin
                    mem[wr_addr][i*`ZT_LANE_W +: `ZT_LANE_W] <= wr_data[i*`ZT_LANE_W +: `ZT_LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (en && rd_en) begin
            rd_data <= fwd;
        end
    end

endmodule : zt_mem_array

`default_nettype wire

// ===== verilog/zt_sram_port.sv
// Zero-turnaround synchronous SRAM port with burst counter
// ****************************************************************
// Summary of operation
// - Address and control taken on one edge; data moves in the next cycle.
// - Reads and writes may follow each other with no idle cycle.
// - Clock gate high: access inputs ignored and access state held; sleep sync, sleep drive-off and output enable still act.
// - Deselect starts no access but finishes the pending data transfer.
// - Data lines float one cycle after a deselect or a write start.
// - Selected only when both low enables low and high enable high.
// - Load while selected captures address and direction.
// - Load while deselected ends any burst in progress.
// - Advance steps the burst counter and ignores the address lines.
// - Up to four words come from one loaded address.
// - Order select high gives interleaved order, low gives linear.
// - On a load, read/write select high reads, low writes.
// - Each nine-bit lane has its own write enable, applied a cycle later.
// - Lane enables ignored on read loads and on advances of a read burst.
// - Write data registered on the edge; read path has no output stage.
// - Output enable high floats data pins at once, without the clock.
// - All sampling and output timing uses the rising clock edge.
// - Sleep input gates the clock internally and keeps stored data.
// - Array is 256K x 36 with four lanes or 256K x 18 with two; ADDR_W sets the depth.
// - Burst continues previous direction; after deselect it is a no-op.
// ****************************************************************
`default_nettype none
`include "zt_params.svh"

module zt_sram_port
    import zt_pkg::*;
#(
    parameter int ADDR_W = `ZT_ADDR_W,
    parameter int LANES  = `ZT_LANES
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         clock_gate_n,
    input  wire logic                         select_low_a,
    input  wire logic                         select_high_or_low_b,
    input  wire logic                         select_low_c_n,
    input  wire logic                         advance_or_load,
    input  wire logic                         read_write_select,
    input  wire logic [LANES-1:0]             byte_lane_write_n,
    input  wire logic                         burst_order_select,
    input  wire logic                         sleep_request,
    input  wire logic                         output_enable_n,
    input  wire logic [ADDR_W-1:0]            address_inputs,
    input  wire logic [LANES*`ZT_BYTE_W-1:0]  data_lines_in,
    output logic      [LANES*`ZT_BYTE_W-1:0]  data_lines_out,
    output logic                              data_lines_oe,
    input  wire logic [LANES-1:0]             parity_data_lines_in,
    output logic      [LANES-1:0]             parity_data_lines_out,
    output logic                              parity_data_lines_oe,
    output logic                              sleep_active
);

    localparam int WORD_W = LANES * `ZT_LANE_W;

    typedef struct packed {
        logic [2:0]              sleep_sync;
        logic                    asleep;
        zt_op_t                  op;
        logic [ADDR_W-1:0]       base;
        logic [`ZT_BURST_W-1:0]  cnt;
        logic                    drive;
        logic                    pend_wr;
        logic [ADDR_W-1:0]       pend_addr;
        logic [LANES-1:0]        pend_lanes;
    } zt_state_t;

    zt_state_t                q;
    zt_state_t                next_q;
    logic                     active;
    logic                     selected;
    logic                     load_now;
    logic [`ZT_BURST_W-1:0]   seq_base;
    logic [`ZT_BURST_W-1:0]   seq_cnt;
    logic [`ZT_BURST_W-1:0]   seq_low;
    logic [ADDR_W-1:0]        acc_addr;
    logic                     rd_en;
    logic                     wr_en;
    logic [WORD_W-1:0]        wr_word;
    logic [WORD_W-1:0]        rd_word;

    // ****************************************************************
    // Access decode
    // ****************************************************************
    assign selected = !select_low_a && select_high_or_low_b && !select_low_c_n;
    assign active   = !clock_gate_n && !q.asleep;
    assign load_now = !advance_or_load;

    // Loads start the sequence at count zero; advances use the next count
    assign seq_base = load_now ? address_inputs[`ZT_BURST_W-1:0] : q.base[`ZT_BURST_W-1:0];
    assign seq_cnt  = load_now ? `ZT_BURST_FIRST : q.cnt + `ZT_BURST_STEP;

    zt_burst_seq u_seq (
        .base_low    (seq_base),
        .count       (seq_cnt),
        .interleaved (burst_order_select),
        .addr_low    (seq_low)
    );

    // Advance ignores the address pins: upper bits come from the loaded base
    assign acc_addr = load_now ? {address_inputs[ADDR_W-1:`ZT_BURST_W], seq_low}
                               : {q.base[ADDR_W-1:`ZT_BURST_W], seq_low};

    // Lane i holds one data byte plus its parity bit
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            wr_word[i*`ZT_LANE_W +: `ZT_BYTE_W]      = data_lines_in[i*`ZT_BYTE_W +: `ZT_BYTE_W];
            wr_word[i*`ZT_LANE_W + `ZT_PARITY_POS]   = parity_data_lines_in[i];
            data_lines_out[i*`ZT_BYTE_W +: `ZT_BYTE_W] = rd_word[i*`ZT_LANE_W +: `ZT_BYTE_W];
            parity_data_lines_out[i]                 = rd_word[i*`ZT_LANE_W + `ZT_PARITY_POS];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_q            = q;
        rd_en             = 1'b0;
        wr_en             = 1'b0;
        next_q.sleep_sync = {q.sleep_sync[1:0], sleep_request};
        // Sleep level changes only once the two later stages agree
        if (q.sleep_sync[1] == q.sleep_sync[2]) begin
            next_q.asleep = q.sleep_sync[2];
        end
        if (q.asleep) begin
            next_q.drive = 1'b0;
        end
        if (active) begin
            // Pending write lands now whatever this cycle brings
            wr_en          = q.pend_wr;
            next_q.pend_wr = 1'b0;
            next_q.drive   = 1'b0;
            if (load_now) begin
                if (selected) begin
                    next_q.base = address_inputs;
                    next_q.cnt  = `ZT_BURST_FIRST;
                    next_q.op   = read_write_select ? ZT_OP_READ : ZT_OP_WRITE;
                end else begin
                    next_q.op = ZT_OP_IDLE;
                end
            end else if (q.op != ZT_OP_IDLE) begin
                next_q.cnt = seq_cnt;
            end
            // Direction comes from the new load or from the burst in flight
            if (next_q.op == ZT_OP_READ && (selected || !load_now)) begin
                rd_en        = 1'b1;
                next_q.drive = 1'b1;
            end else if (next_q.op == ZT_OP_WRITE && (selected || !load_now)) begin
                next_q.pend_wr    = 1'b1;
                next_q.pend_addr  = acc_addr;
                next_q.pend_lanes = ~byte_lane_write_n;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.sleep_sync <= `ZT_RST_SYNC;
            q.asleep     <= `ZT_RST_BIT;
            q.op         <= ZT_OP_IDLE;
            q.base       <= '0;
            q.cnt        <= `ZT_BURST_FIRST;
            q.drive      <= `ZT_RST_BIT;
            q.pend_wr    <= `ZT_RST_BIT;
            q.pend_addr  <= '0;
            q.pend_lanes <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // Storage
    // ****************************************************************
    zt_mem_array #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES)
    ) u_mem (
        .clk      (clk),
        .rst_n    (rst_n),
        .en       (active),
        .rd_en    (rd_en),
        .rd_addr  (acc_addr),
        .rd_data  (rd_word),
        .wr_en    (wr_en),
        .wr_addr  (q.pend_addr),
        .wr_lanes (q.pend_lanes),
        .wr_data  (wr_word)
    );

    // Output enable must cut the drive without waiting for a clock edge
    assign data_lines_oe        = q.drive && !output_enable_n;
    assign parity_data_lines_oe = q.drive && !output_enable_n;
    assign sleep_active         = q.asleep;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_load_read;
        active && load_now && selected && read_write_select;
    endsequence

    sequence s_load_write;
        active && load_now && selected && !read_write_select;
    endsequence

    property p_read_next_cycle;
        s_load_read |=> q.drive && (q.op == ZT_OP_READ);
    endproperty
    a_read_next_cycle: assert property (p_read_next_cycle)
        else $error("read load did not drive data in the next cycle");

    property p_write_then_read;
        s_load_write ##1 s_load_read |=> q.drive && !q.pend_wr;
    endproperty
    a_write_then_read: assert property (p_write_then_read)
        else $error("read right after write was not served");

    // Sleep entry may still pull the drive low while the gate is held high
    property p_gate_holds;
        clock_gate_n && !sleep_active |=> $stable(q.drive) && $stable(q.cnt) && $stable(q.op)
            && $stable(q.pend_wr) && $stable(rd_word);
    endproperty
    a_gate_holds: assert property (p_gate_holds)
        else $error("state moved while clock gate was high");

    property p_deselect_finishes_write;
        active && q.pend_wr && load_now && !selected |-> wr_en ##1 q.op == ZT_OP_IDLE;
    endproperty
    a_deselect_finishes_write: assert property (p_deselect_finishes_write)
        else $error("pending write dropped on deselect");

    property p_float_after_deselect;
        active && load_now && (!selected || !read_write_select) |=> !data_lines_oe;
    endproperty
    a_float_after_deselect: assert property (p_float_after_deselect)
        else $error("data lines driven after deselect or write start");

    property p_load_captures;
        s_load_read or s_load_write |=> q.base == $past(address_inputs) && q.cnt == `ZT_BURST_FIRST;
    endproperty
    a_load_captures: assert property (p_load_captures)
        else $error("load did not capture the address");

    property p_advance_steps;
        active && !load_now && q.op != ZT_OP_IDLE |=> q.cnt == $past(q.cnt) + `ZT_BURST_STEP && $stable(q.base);
    endproperty
    a_advance_steps: assert property (p_advance_steps)
        else $error("burst counter did not step on advance");

    property p_write_lanes;
        s_load_write |=> q.pend_wr && q.pend_lanes == ~$past(byte_lane_write_n);
    endproperty
    a_write_lanes: assert property (p_write_lanes)
        else $error("lane enables not captured for write");

    property p_read_ignores_lanes;
        s_load_read |=> !q.pend_wr;
    endproperty
    a_read_ignores_lanes: assert property (p_read_ignores_lanes)
        else $error("read load started a write");

    property p_noop_floats;
        active && !load_now && q.op == ZT_OP_IDLE |=> !q.drive && !q.pend_wr;
    endproperty
    a_noop_floats: assert property (p_noop_floats)
        else $error("burst after deselect was not a no-op");

    property p_oe_async;
        output_enable_n |-> !data_lines_oe && !parity_data_lines_oe;
    endproperty
    a_oe_async: assert property (p_oe_async)
        else $error("data lines driven while output enable high");

    property p_sleep_floats;
        sleep_active |=> !q.drive;
    endproperty
    a_sleep_floats: assert property (p_sleep_floats)
        else $error("data lines driven while asleep");

    property p_interleave_order;
        active && !load_now && q.op != ZT_OP_IDLE && burst_order_select
            |-> acc_addr[1:0] == (q.base[1:0] ^ (q.cnt + `ZT_BURST_STEP));
    endproperty
    a_interleave_order: assert property (p_interleave_order)
        else $error("interleaved burst address wrong");

    property p_linear_order;
        active && !load_now && q.op != ZT_OP_IDLE && !burst_order_select
            |-> acc_addr == {q.base[ADDR_W-1:2], q.base[1:0] + q.cnt + `ZT_BURST_STEP};
    endproperty
    a_linear_order: assert property (p_linear_order)
        else $error("linear burst address wrong");

endmodule : zt_sram_port

`default_nettype wire

// ===== sim/zt_host_model.sv
// Host controller model that turns bench commands into SRAM pin levels
`default_nettype none

module zt_host_model #(
    parameter int AW = 6
) (
    input  wire logic          clk,
    input  wire logic [2:0]    kind,
    input  wire logic [AW-1:0] addr,
    input  wire logic [3:0]    lanes_n,
    input  wire logic [1:0]    drop,
    input  wire logic          wvalid,
    input  wire logic [35:0]   wdata,
    input  wire logic [31:0]   junk,
    input  wire logic          order,
    output logic               clock_gate_n,
    output logic               select_low_a,
    output logic               select_high_or_low_b,
    output logic               select_low_c_n,
    output logic               advance_or_load,
    output logic               read_write_select,
    output logic [3:0]         byte_lane_write_n,
    output logic               burst_order_select,
    output logic [AW-1:0]      address_inputs,
    output logic [31:0]        data_lines_in,
    output logic [3:0]         parity_data_lines_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] last_w = 36'h0;
    logic [35:0] drv;

    always_ff @(posedge clk) begin
        if (wvalid) begin
            last_w <= wdata;
        end
    end

    // Kinds: 0 load read, 1 load write, 2 advance, 3 deselect, 4 suspend, 5 junk
    always_comb begin
        // Released data lines show the inverse of the last word, so stale data never passes
        drv = wvalid ? wdata : ~last_w;
        for (int i = 0; i < 4; i++) begin
            data_lines_in[8*i +: 8] = drv[9*i +: 8];
            parity_data_lines_in[i] = drv[9*i+8];
        end
        clock_gate_n = (kind == 3'h4);
        burst_order_select = order;
        {select_low_a, select_high_or_low_b, select_low_c_n, read_write_select} = junk[3:0];
        advance_or_load = junk[4];
        address_inputs = junk[AW+7:8];
        byte_lane_write_n = lanes_n;
        if (kind <= 3'h1) begin
            {select_low_a, select_high_or_low_b, select_low_c_n} = 3'h2;
            advance_or_load = 1'b0;
            read_write_select = (kind == 3'h0);
            address_inputs = addr;
        end
        if (kind == 3'h2) begin
            // Selects and address stay random: an advance must ignore them
            advance_or_load = 1'b1;
        end
        if (kind == 3'h3) begin
            select_low_a = junk[0] | (drop == 2'h0);
            select_high_or_low_b = junk[1] & (drop != 2'h1);
            select_low_c_n = junk[2] | (drop == 2'h2);
            advance_or_load = 1'b0;
        end
    end
endmodule : zt_host_model

`default_nettype wire

// ===== sim/zt_sram_port_tb.sv
// Self-checking bench for the zero-turnaround SRAM port
`default_nettype none

module zt_sram_port_tb
    import zt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 6;
    logic clk, rst_n, wvalid, order, sleep_request, output_enable_n;
    logic [2:0] kind;
    logic [AW-1:0] addr, base, paddr, address_inputs;
    logic [3:0] lanes_n, plane, byte_lane_write_n, parity_data_lines_in, parity_data_lines_out;
    logic [1:0] drop, cnt;
    logic [35:0] wdata;
    logic [31:0] junk, data_lines_in, data_lines_out;
    logic clock_gate_n, select_low_a, select_high_or_low_b, select_low_c_n, advance_or_load;
    logic read_write_select, burst_order_select, data_lines_oe, parity_data_lines_oe, sleep_active;
    logic [35:0] mem [64];
    zt_op_t pend, dir;
    int n_mismatch = 0;
    int total_checks = 0;

    zt_host_model #(.AW(AW)) host (.clk(clk), .kind(kind), .addr(addr), .lanes_n(lanes_n), .drop(drop),
        .wvalid(wvalid), .wdata(wdata), .junk(junk), .order(order), .clock_gate_n(clock_gate_n),
        .select_low_a(select_low_a), .select_high_or_low_b(select_high_or_low_b),
        .select_low_c_n(select_low_c_n), .advance_or_load(advance_or_load),
        .read_write_select(read_write_select), .byte_lane_write_n(byte_lane_write_n),
        .burst_order_select(burst_order_select), .address_inputs(address_inputs),
        .data_lines_in(data_lines_in), .parity_data_lines_in(parity_data_lines_in));

    zt_sram_port #(.ADDR_W(AW), .LANES(4)) uut (.clk(clk), .rst_n(rst_n), .clock_gate_n(clock_gate_n),
        .select_low_a(select_low_a), .select_high_or_low_b(select_high_or_low_b),
        .select_low_c_n(select_low_c_n), .advance_or_load(advance_or_load),
        .read_write_select(read_write_select), .byte_lane_write_n(byte_lane_write_n),
        .burst_order_select(burst_order_select), .sleep_request(sleep_request),
        .output_enable_n(output_enable_n), .address_inputs(address_inputs), .data_lines_in(data_lines_in),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
        .parity_data_lines_in(parity_data_lines_in), .parity_data_lines_out(parity_data_lines_out),
        .parity_data_lines_oe(parity_data_lines_oe), .sleep_active(sleep_active));

    // ****************************************************************
    // Checking and verdict
    // ****************************************************************
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [35:0] pack(input logic [31:0] d, input logic [3:0] p);
        for (int i = 0; i < 4; i++) begin
            pack[9*i +: 9] = {p[i], d[8*i +: 8]};
        end
    endfunction : pack

    // Outputs launched by the edge just passed; a suspend leaves them standing
    task automatic check_out();
        if (pend == ZT_OP_READ && !output_enable_n) begin
            check("read_oe", 36'(data_lines_oe & parity_data_lines_oe), 36'h1);
            check("read_data", pack(data_lines_out, parity_data_lines_out), mem[paddr]);
        end else begin
            check("float_oe", 36'(data_lines_oe | parity_data_lines_oe), 36'h0);
        end
    endtask : check_out

    // ****************************************************************
    // One bus cycle: drive at the falling edge, then step the model
    // ****************************************************************
    task automatic step(input logic [2:0] k, input logic [AW-1:0] a, input logic [3:0] ln);
        @(negedge clk);
        check_out();
        kind = k;
        addr = a;
        lanes_n = ln;
        drop = 2'($urandom_range(2));
        junk = $urandom;
        output_enable_n = ($urandom_range(9) == 0);
        if (k != 3'h4) begin
            wdata = {$urandom, 4'($urandom)};
        end
        wvalid = (pend == ZT_OP_WRITE);
        #1;
        check("async_oe", 36'(data_lines_oe), 36'(pend == ZT_OP_READ && !output_enable_n));
        if (k >= 3'h4) begin
            return;
        end
        for (int i = 0; i < 4; i++) begin
            if (pend == ZT_OP_WRITE && !plane[i]) begin
                mem[paddr][9*i +: 9] = wdata[9*i +: 9];
            end
        end
        case (k)
            3'h0, 3'h1: begin
                dir = (k == 3'h0) ? ZT_OP_READ : ZT_OP_WRITE;
                base = a;
                cnt = 2'h0;
                paddr = a;
            end
            3'h2: begin
                cnt = cnt + 2'h1;
                paddr = {base[AW-1:2], order ? (base[1:0] ^ cnt) : (base[1:0] + cnt)};
            end
            default: dir = ZT_OP_IDLE;
        endcase
        pend = dir;
        plane = ln;
    endtask : step

    task automatic rand_run(input int n);
        int r;
        for (int j = 0; j < n; j++) begin
            r = $urandom_range(19);
            step((r < 6) ? 3'h0 : (r < 11) ? 3'h1 : (r < 16) ? 3'h2 : (r < 18) ? 3'h3 : 3'h4,
                AW'($urandom), 4'($urandom));
        end
    endtask : rand_run

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        void'($urandom(10162));
        {rst_n, wvalid, order, sleep_request, output_enable_n} = 5'h0;
        kind = 3'h3;
        {addr, base, paddr, lanes_n, plane, drop, cnt, wdata, junk} = '0;
        pend = ZT_OP_IDLE;
        dir = ZT_OP_IDLE;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check("reset_oe", 36'(data_lines_oe), 36'h0);
        check("reset_sleep", 36'(sleep_active), 36'h0);
        // Whole-word writes fill the array so that every later read is defined
        for (int i = 0; i < 64; i++) begin
            step(3'h1, AW'(i), 4'h0);
        end
        for (int ph = 0; ph < 2; ph++) begin
            step(3'h3, '0, '0);
            order = ph[0];
            rand_run(400);
        end
        step(3'h3, '0, '0);
        sleep_request = 1'b1;
        for (int j = 0; j < 8 && sleep_active !== 1'b1; j++) begin
            step(3'h3, '0, '0);
        end
        check("sleep_on", 36'(sleep_active), 36'h1);
        repeat (8) step(3'h5, AW'($urandom), 4'($urandom));
        sleep_request = 1'b0;
        for (int j = 0; j < 8 && sleep_active !== 1'b0; j++) begin
            step(3'h3, '0, '0);
        end
        check("sleep_off", 36'(sleep_active), 36'h0);
        rand_run(200);
        give_verdict();
    end
endmodule : zt_sram_port_tb

`default_nettype wire
